// ---- rtl/tfpc_timer8.sv ----
// The placing of the registers and the AHB-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/1ns
// What this block does
// - Mode select 3 or 7 runs single-slope fast PWM.
// - Fast PWM TOP is 0xFF in mode 3, compare A in mode 7.
// - Fast PWM counts up on each tick to TOP, then wraps to zero.
// - Fast non-inverting clears on match, sets at bottom; inverting the opposite.
// - Action two is non-inverted PWM, action three inverted PWM.
// - Fast PWM sets the overflow flag whenever the counter reaches TOP.
// - Fast PWM action one toggles output A on match only with mode bit 2.
// - Pin shows compare state only while its direction bit selects output.
// - Compare zero gives a one-tick spike; compare MAX a constant level.
// - Toggle on match yields 50% square wave, half clock at compare zero.
// - In fast PWM compare values are double buffered.
// - With TOP 0xFF fast PWM period is 256 ticks.
// - Mode select 1 or 5 runs dual-slope phase-correct PWM.
// - Phase-correct TOP is 0xFF in mode 1, compare A in mode 5.
// - Phase-correct counts up to TOP, turns on the next tick, counts down to bottom, repeats.
// - Phase-correct non-inverting clears on up match, sets on down match.
// - Phase-correct sets the overflow flag each time the counter reaches bottom.
// - Phase-correct action one toggles output A on match only with mode bit 2.
// - Phase-correct with TOP 0xFF has a period of 510 ticks.
// - Phase-correct compare zero holds low, MAX holds high; inverted opposite.
// - Phase-correct at TOP output takes up-match level unless compare equals TOP.
// - Action zero does nothing on match and gives the pin back to the port.
// - Reset clears both internal compare output states.
module tfpc_timer8 (
  // Clock and reset
  input  wire logic             core_clk,
  input  wire logic             rst_n,
  // Prescaled timer tick from the same clock domain
  input  wire logic             timer_tick,
  // AHB-Lite slave
  input  wire logic             hsel,
  input  wire logic [31:0]      haddr,
  input  wire logic [1:0]       htrans,
  input  wire logic             hwrite,
  input  wire logic [2:0]       hsize,
  input  wire logic             hready,
  input  wire logic [31:0]      hwdata,
  output logic      [31:0]      hrdata,
  output logic                  hreadyout,
  output logic                  hresp,
  // Compare pins toward the power stage
  output tfpc_pkg::tfpc_pin_s   compare_output_a,
  output tfpc_pkg::tfpc_pin_s   compare_output_b
);
  import tfpc_pkg::*;

  // Register map, one word per register, payload in the low byte:
  //   CTRL   [7:6] action A, [5:4] action B, bit 3 reads zero, [2:0] waveform mode
  //   COUNT  live counter value, writable at any time
  //   CMPA   compare A buffer; it also sets TOP in modes 5 and 7
  //   CMPB   compare B buffer
  //   STATUS [0] overflow flag, write one to clear; [1] counting down, read only
  //   PIN    [0] dir A, [1] dir B, [2] port level A, [3] port level B,
  //          [4] compare state A, [5] compare state B, both read only
  // Unmapped offsets read zero and ignore writes; every transfer is zero wait.

  // State registers
  tfpc_ctrl_s  ctrl_reg;
  logic [7:0]  counter_value_reg;
  logic        count_down_reg;
  logic [7:0]  cmp_buf_reg [2];
  logic [7:0]  cmp_act_reg [2];
  logic [1:0]  oc_reg;
  logic        overflow_flag_reg;
  logic [3:0]  pin_ctrl_reg;
  logic        block_match_reg;
  logic        wr_pend_reg;
  logic [7:0]  wr_addr_reg;
  logic [31:0] hrdata_reg;

  // Decoded and next-state signals
  logic        mode_fast;
  logic        mode_pc;
  logic        mode_pwm;
  logic        waveform_mode_bit2;
  logic [7:0]  top_value;
  logic        at_top;
  logic        at_bottom;
  logic        load_cmp;
  logic        addr_phase;
  logic        wr_count;
  logic        wr_cmp   [2];
  logic [1:0]  act      [2];
  logic [1:0]  oc_next;
  logic [1:0]  connected;

  // Mode decode
  // Even modes are not PWM here: the counter and both compare states stand still
  assign waveform_mode_bit2 = ctrl_reg.waveform_mode_select[2];
  assign mode_fast = (ctrl_reg.waveform_mode_select == TFPC_MODE_FAST_FIX)
                  || (ctrl_reg.waveform_mode_select == TFPC_MODE_FAST_VAR);
  assign mode_pc   = (ctrl_reg.waveform_mode_select == TFPC_MODE_PC_FIX)
                  || (ctrl_reg.waveform_mode_select == TFPC_MODE_PC_VAR);
  assign mode_pwm  = mode_fast || mode_pc;

  // TOP is fixed or follows the active compare A value
  // Phase-correct only sees TOP on the up slope, so the turn is taken once
  assign top_value = waveform_mode_bit2 ? cmp_act_reg[0] : TFPC_MAX;
  assign at_top    = (counter_value_reg == top_value) && !(mode_pc && count_down_reg);
  assign at_bottom = (counter_value_reg == TFPC_BOTTOM);

  // Buffered compare values move over at TOP so a period is never torn
  assign load_cmp  = mode_pwm && timer_tick && at_top;

  // Bus decode, sampled only on a valid address phase
  // Transfer size is not decoded: every register is a full word, so a narrow
  // write still updates the whole low byte.
  assign addr_phase = hsel && htrans[1] && hready;
  assign wr_count   = wr_pend_reg && (wr_addr_reg == TFPC_COUNT_OFS);
  assign wr_cmp[0]  = wr_pend_reg && (wr_addr_reg == TFPC_CMPA_OFS);
  assign wr_cmp[1]  = wr_pend_reg && (wr_addr_reg == TFPC_CMPB_OFS);
  assign act[0]     = ctrl_reg.output_action_a;
  assign act[1]     = ctrl_reg.output_action_b;

  // Zero-wait slave, always OKAY
  // Every register answers in the data phase, so no wait state is ever inserted
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_reg;

  // Address phase capture
  // Writes apply at the end of the data phase, when the write data is valid;
  // only the low address byte is kept, so the map repeats every 256 bytes.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
    end else begin
      wr_pend_reg <= addr_phase && hwrite;
      if (addr_phase) begin
        wr_addr_reg <= haddr[7:0];
      end
    end
  end

  // Read data is latched at the address phase, so it reflects that edge's state
  // A read right after a write to the same register still returns the old value
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      hrdata_reg <= 32'h0000_0000;
    end else if (addr_phase && !hwrite) begin
      hrdata_reg <= 32'h0000_0000;
      if (haddr[7:0] == TFPC_CTRL_OFS) begin
        hrdata_reg[7:0] <= {ctrl_reg.output_action_a, ctrl_reg.output_action_b, 1'b0,
                            ctrl_reg.waveform_mode_select};
      end else if (haddr[7:0] == TFPC_COUNT_OFS) begin
        hrdata_reg[7:0] <= counter_value_reg;
      end else if (haddr[7:0] == TFPC_CMPA_OFS) begin
        hrdata_reg[7:0] <= cmp_buf_reg[0];
      end else if (haddr[7:0] == TFPC_CMPB_OFS) begin
        hrdata_reg[7:0] <= cmp_buf_reg[1];
      end else if (haddr[7:0] == TFPC_STATUS_OFS) begin
        hrdata_reg[TFPC_OVF_BIT]  <= overflow_flag_reg;
        hrdata_reg[TFPC_DOWN_BIT] <= count_down_reg;
      end else if (haddr[7:0] == TFPC_PIN_OFS) begin
        hrdata_reg[3:0]           <= pin_ctrl_reg;
        hrdata_reg[TFPC_OCA_BIT]  <= oc_reg[0];
        hrdata_reg[TFPC_OCB_BIT]  <= oc_reg[1];
      end
    end
  end

  // Control and pin registers; action changes take effect at once
  // Action bits are not buffered with the compare values, so a change
  // in mid-period can cut or stretch one pulse.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_reg     <= TFPC_CTRL_RST[6:0];
      pin_ctrl_reg <= TFPC_PIN_RST[3:0];
    end else if (wr_pend_reg) begin
      if (wr_addr_reg == TFPC_CTRL_OFS) begin
        ctrl_reg.output_action_a      <= hwdata[TFPC_ACTA_LSB +: 2];
        ctrl_reg.output_action_b      <= hwdata[TFPC_ACTB_LSB +: 2];
        ctrl_reg.waveform_mode_select <= hwdata[TFPC_MODE_LSB +: 3];
      end else if (wr_addr_reg == TFPC_PIN_OFS) begin
        pin_ctrl_reg <= hwdata[3:0];
      end
    end
  end

  // Compare buffers and active copies, one per channel
  // Outside the PWM modes a write goes straight through, since there is no
  // period boundary there to protect.
  for (genvar ch = 0; ch < 2; ch++) begin : g_cmp
    always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
        cmp_buf_reg[ch] <= TFPC_CMP_RST;
        cmp_act_reg[ch] <= TFPC_CMP_RST;
      end else begin
        if (wr_cmp[ch]) begin
          cmp_buf_reg[ch] <= hwdata[7:0];
        end
        if (!mode_pwm && wr_cmp[ch]) begin
          cmp_act_reg[ch] <= hwdata[7:0];    // Non-PWM modes write through
        end else if (load_cmp) begin
          cmp_act_reg[ch] <= cmp_buf_reg[ch];
        end
      end
    end
  end

  // Counter sequencing; a software write wins over a tick
  // A write above TOP in mode 7 runs on to 0xFF and rolls over to zero without
  // a TOP event, so neither the flag nor the buffer load happens that period.
  // Mode changes keep the count and the direction, so software should stop
  // the counter and rewrite it before starting a new mode.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      counter_value_reg <= TFPC_BOTTOM;
      count_down_reg    <= 1'b0;
    end else if (wr_count) begin
      counter_value_reg <= hwdata[7:0];
    end else if (timer_tick && mode_fast) begin
      count_down_reg <= 1'b0;
      if (at_top) begin
        counter_value_reg <= TFPC_BOTTOM;
      end else begin
        counter_value_reg <= counter_value_reg + 8'h01;
      end
    end else if (timer_tick && mode_pc) begin
      if (at_top) begin
        count_down_reg    <= !at_bottom;
        counter_value_reg <= at_bottom ? TFPC_BOTTOM : counter_value_reg - 8'h01;
      end else if (count_down_reg && at_bottom) begin
        count_down_reg    <= 1'b0;
        counter_value_reg <= counter_value_reg + 8'h01;
      end else if (count_down_reg) begin
        counter_value_reg <= counter_value_reg - 8'h01;
      end else begin
        counter_value_reg <= counter_value_reg + 8'h01;
      end
    end
  end

  // Overflow flag: hardware set wins over a write-one clear in the same cycle
  // One priority chain, so a flag raised in the clear cycle is never lost
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      overflow_flag_reg <= 1'b0;
    end else if (timer_tick && mode_fast && at_top) begin
      overflow_flag_reg <= 1'b1;
    end else if (timer_tick && mode_pc && at_bottom) begin
      overflow_flag_reg <= 1'b1;
    end else if (wr_pend_reg && (wr_addr_reg == TFPC_STATUS_OFS)
                 && hwdata[TFPC_OVF_BIT]) begin
      overflow_flag_reg <= 1'b0;
    end
  end

  // A counter write blocks any match on the next tick
  // This lets software preset COUNT to a compare value without an edge; the
  // price is that a write equal to a compare value skips that match.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      block_match_reg <= 1'b0;
    end else if (wr_count) begin
      block_match_reg <= 1'b1;
    end else if (timer_tick) begin
      block_match_reg <= 1'b0;
    end
  end

  // Next compare output state per channel
  // Channel B has no toggle option; in the PWM modes its action one leaves the pin with the port
  for (genvar ch = 0; ch < 2; ch++) begin : g_wave
    logic match;
    logic toggle_ok;
    logic pwm_act;
    logic cmp_is_top;
    logic up_level;
    assign match      = (counter_value_reg == cmp_act_reg[ch]) && !block_match_reg;
    assign toggle_ok  = (ch == 0) && waveform_mode_bit2
                     && (act[ch] == TFPC_ACT_TOGGLE);
    assign pwm_act    = act[ch][1];
    assign cmp_is_top = (cmp_act_reg[ch] == top_value);
    assign up_level   = (act[ch] == TFPC_ACT_INV);    // Level left by an up-count match

    // Priority: no tick or no PWM mode holds, then toggle, then disconnected
    // actions hold, then the slope rules of the running mode
    always_comb begin
      oc_next[ch] = oc_reg[ch];
      if (!timer_tick || !mode_pwm) begin
        oc_next[ch] = oc_reg[ch];
      end else if (toggle_ok) begin
        if (match) begin
          oc_next[ch] = !oc_reg[ch];
        end
      end else if (!pwm_act) begin
        oc_next[ch] = oc_reg[ch];
      end else if (mode_fast) begin
        // Wrap action beats a match at TOP, giving constant level at MAX
        if (at_top) begin
          oc_next[ch] = !up_level;
        end else if (match) begin
          oc_next[ch] = up_level;
        end
      end else begin
        // Bottom counts as up-going so compare zero stays flat
        // At TOP the up-match level is forced unless compare equals TOP, so the wave stays symmetric
        if (at_top) begin
          oc_next[ch] = cmp_is_top ? !up_level : up_level;
        end else if (match && (count_down_reg && !at_bottom)) begin
          oc_next[ch] = !up_level;
        end else if (match) begin
          oc_next[ch] = up_level;
        end
      end
    end

    // Pin is taken from the port unless the action connects the waveform
    assign connected[ch] = (act[ch] != TFPC_ACT_OFF)
                        && !(mode_pwm && (act[ch] == TFPC_ACT_TOGGLE) && !toggle_ok);
  end

  // Internal compare output states
  // These survive mode changes, so a new mode starts from the last level
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      oc_reg <= 2'b00;
    end else begin
      oc_reg <= oc_next;
    end
  end

  // Pin drive: level from waveform or port bit, enable from direction bit
  // Registered from the same next-state value as the internal state, so pin
  // and state change on the same edge with no glitch.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      compare_output_a <= '0;
      compare_output_b <= '0;
    end else begin
      compare_output_a.out <= connected[0] ? oc_next[0] : pin_ctrl_reg[TFPC_PORTA_BIT];
      compare_output_a.oe  <= pin_ctrl_reg[TFPC_DIRA_BIT];
      compare_output_b.out <= connected[1] ? oc_next[1] : pin_ctrl_reg[TFPC_PORTB_BIT];
      compare_output_b.oe  <= pin_ctrl_reg[TFPC_DIRB_BIT];
    end
  end
endmodule : tfpc_timer8

// ---- rtl/tfpc_pkg.sv ----
package tfpc_pkg;
  // Register byte offsets
  localparam logic [7:0] TFPC_CTRL_OFS   = 8'h00;
  localparam logic [7:0] TFPC_COUNT_OFS  = 8'h04;
  localparam logic [7:0] TFPC_CMPA_OFS   = 8'h08;
  localparam logic [7:0] TFPC_CMPB_OFS   = 8'h0C;
  localparam logic [7:0] TFPC_STATUS_OFS = 8'h10;
  localparam logic [7:0] TFPC_PIN_OFS    = 8'h14;
  // Control field positions
  localparam int TFPC_MODE_LSB = 0;
  localparam int TFPC_ACTB_LSB = 4;
  localparam int TFPC_ACTA_LSB = 6;
  // Status and pin field positions
  localparam int TFPC_OVF_BIT   = 0;
  localparam int TFPC_DOWN_BIT  = 1;
  localparam int TFPC_DIRA_BIT  = 0;
  localparam int TFPC_DIRB_BIT  = 1;
  localparam int TFPC_PORTA_BIT = 2;
  localparam int TFPC_PORTB_BIT = 3;
  localparam int TFPC_OCA_BIT   = 4;
  localparam int TFPC_OCB_BIT   = 5;
  // Reset values
  localparam logic [7:0] TFPC_CTRL_RST = 8'h00;
  localparam logic [7:0] TFPC_CMP_RST  = 8'h00;
  localparam logic [7:0] TFPC_PIN_RST  = 8'h00;
  // Counter limits
  localparam logic [7:0] TFPC_BOTTOM   = 8'h00;
  localparam logic [7:0] TFPC_MAX      = 8'hFF;
  // Waveform modes
  localparam logic [2:0] TFPC_MODE_PC_FIX   = 3'h1;
  localparam logic [2:0] TFPC_MODE_FAST_FIX = 3'h3;
  localparam logic [2:0] TFPC_MODE_PC_VAR   = 3'h5;
  localparam logic [2:0] TFPC_MODE_FAST_VAR = 3'h7;
  // Output actions
  localparam logic [1:0] TFPC_ACT_OFF    = 2'h0;
  localparam logic [1:0] TFPC_ACT_TOGGLE = 2'h1;
  localparam logic [1:0] TFPC_ACT_NONINV = 2'h2;
  localparam logic [1:0] TFPC_ACT_INV    = 2'h3;

  // One compare pin: level and driver enable
  typedef struct packed {
    logic out;
    logic oe;
  } tfpc_pin_s;

  // Software control fields
  typedef struct packed {
    logic [1:0] output_action_a;
    logic [1:0] output_action_b;
    logic [2:0] waveform_mode_select;
  } tfpc_ctrl_s;
endpackage : tfpc_pkg

// ---- bench/tfpc_timer8_sva.sv ----
`timescale 1ns/1ns
module tfpc_timer8_sva (
  // Clock, reset and tick
  input wire logic                core_clk,
  input wire logic                rst_n,
  input wire logic                timer_tick,
  // Bus
  input wire logic                hsel,
  input wire logic [31:0]         haddr,
  input wire logic [1:0]          htrans,
  input wire logic                hwrite,
  input wire logic                hready,
  input wire logic [31:0]         hwdata,
  input wire logic                hreadyout,
  input wire logic                hresp,
  // Pins
  input wire tfpc_pkg::tfpc_pin_s compare_output_a,
  input wire tfpc_pkg::tfpc_pin_s compare_output_b
);
  import tfpc_pkg::*;
  logic       wr_dp;
  logic [7:0] wa;
  tfpc_ctrl_s ctl;
  logic [3:0] pin;
  logic       pwm;
  // Shadow of control and pin setup, so pin checks know the programmed state
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_dp <= 1'b0;
      wa    <= 8'h00;
      ctl   <= '0;
      pin   <= 4'h0;
    end else begin
      wr_dp <= hsel & htrans[1] & hready & hwrite;
      wa    <= haddr[7:0];
      if (wr_dp && wa == TFPC_CTRL_OFS) ctl <= {hwdata[7:4], hwdata[2:0]};
      if (wr_dp && wa == TFPC_PIN_OFS) pin <= hwdata[3:0];
    end
  end
  // Odd modes are the PWM ones
  assign pwm = ctl.waveform_mode_select[0];
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // Pin checks allow one edge of slack after any register write, the tick and idle checks two
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus slave stalled or answered with an error");
  a_oe_follows_dir: assert property (
    !$past(wr_dp) |-> compare_output_a.oe == pin[0] && compare_output_b.oe == pin[1])
    else $error("pin driver enable differs from direction bit");
  a_off_a_port: assert property (
    ctl.output_action_a == TFPC_ACT_OFF && !$past(wr_dp) |-> compare_output_a.out == pin[2])
    else $error("pin A not at port level with action off");
  a_off_b_port: assert property (
    (ctl.output_action_b == TFPC_ACT_OFF || (pwm && ctl.output_action_b == TFPC_ACT_TOGGLE))
    && !$past(wr_dp) |-> compare_output_b.out == pin[3])
    else $error("pin B not at port level");
  a_no_toggle_a: assert property (
    pwm && ctl.output_action_a == TFPC_ACT_TOGGLE && !ctl.waveform_mode_select[2]
    && !$past(wr_dp) |-> compare_output_a.out == pin[2])
    else $error("pin A toggle without mode bit 2");
  a_tick_only_a: assert property (
    $changed(compare_output_a.out) |-> $past(timer_tick) || $past(wr_dp) || $past(wr_dp, 2))
    else $error("pin A moved without a tick");
  a_tick_only_b: assert property (
    $changed(compare_output_b.out) |-> $past(timer_tick) || $past(wr_dp) || $past(wr_dp, 2))
    else $error("pin B moved without a tick");
  a_idle_hold: assert property (
    !pwm && !$past(wr_dp) && !$past(wr_dp, 2)
    |-> $stable(compare_output_a.out) && $stable(compare_output_b.out))
    else $error("pin moved outside the PWM modes");
  c_rise_a: cover property ($rose(compare_output_a.out));
  c_rise_b: cover property ($rose(compare_output_b.out) && ctl.waveform_mode_select[2]);
  c_oe_drop: cover property ($fell(compare_output_a.oe));
endmodule : tfpc_timer8_sva

bind tfpc_timer8 tfpc_timer8_sva u_tfpc_timer8_sva (
  .core_clk(core_clk), .rst_n(rst_n), .timer_tick(timer_tick), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hwdata(hwdata),
  .hreadyout(hreadyout), .hresp(hresp), .compare_output_a(compare_output_a),
  .compare_output_b(compare_output_b));

// ---- bench/tfpc_power_stage.sv ----
`timescale 1ns/1ns
module tfpc_power_stage (
  // Clock and reset
  input wire logic                core_clk,
  input wire logic                rst_n,
  // Pin from the timer
  input wire tfpc_pkg::tfpc_pin_s pin,
  // Pad level and last measured period and high time
  output logic                    pad,
  output logic [15:0]             period,
  output logic [15:0]             high
);
  import tfpc_pkg::*;
  logic        pad_d;
  logic [15:0] run;
  logic [15:0] hi;
  // Gate input has a pull-down, so an undriven pin reads low
  assign pad = pin.oe ? pin.out : 1'b0;
  // Count clock cycles between rising pad edges
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pad_d  <= 1'b0;
      run    <= 16'h0000;
      hi     <= 16'h0000;
      period <= 16'h0000;
      high   <= 16'h0000;
    end else begin
      pad_d <= pad;
      if (pad && !pad_d) begin
        period <= run;
        high   <= hi;
        run    <= 16'h0001;
        hi     <= 16'h0001;
      end else begin
        run <= run + 16'h0001;
        hi  <= hi + {15'h0000, pad};
      end
    end
  end
endmodule : tfpc_power_stage

// ---- bench/tfpc_timer8_tb_top.sv ----
`timescale 1ns/1ns
module tfpc_timer8_tb_top;
  import tfpc_pkg::*;
  logic        core_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        timer_tick = 1'b1;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata, rd;
  logic        hready, hresp, pad_a, pad_b;
  tfpc_pin_s   pin_a, pin_b;
  logic [15:0] per_a, hi_a, per_b, hi_b;
  logic [7:0]  c;
  logic [7:0]  ofs [7] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h20};
  int          error_cnt = 0;
  int          check_count = 0;
  int          cyc = 0;

  tfpc_timer8 u_tfpc_timer8 (.core_clk(core_clk), .rst_n(rst_n), .timer_tick(timer_tick),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hready(hready), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hready), .hresp(hresp),
    .compare_output_a(pin_a), .compare_output_b(pin_b));
  tfpc_power_stage u_tfpc_power_stage_a (.core_clk(core_clk), .rst_n(rst_n), .pin(pin_a),
    .pad(pad_a), .period(per_a), .high(hi_a));
  tfpc_power_stage u_tfpc_power_stage_b (.core_clk(core_clk), .rst_n(rst_n), .pin(pin_b),
    .pad(pad_b), .period(per_b), .high(hi_b));

  // 125 MHz clock
  always #4 core_clk = ~core_clk;
  // Hang guard, well above the roughly 12000 cycles the tests need
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      summarize();
    end
  end

  task automatic summarize();
    $display("Comparisons %0d, mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : summarize

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : chk

  // One single word transfer; address phase, then data phase, each held until hready
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    hsel   <= 1'b1;
    haddr  <= {24'h000000, a};
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge core_clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge core_clk); while (hready !== 1'b1);
    rd = hrdata;
  endtask : bus

  task automatic rdchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(rd & m, e);
  endtask : rdchk

  // Stop the counter first, so compare writes land directly and each run starts at zero
  task automatic cfg(input logic [7:0] ctl, input logic [7:0] a, input logic [7:0] b);
    bus(1'b1, TFPC_CTRL_OFS, 32'h0);
    bus(1'b1, TFPC_COUNT_OFS, 32'h0);
    bus(1'b1, TFPC_CMPA_OFS, {24'h0, a});
    bus(1'b1, TFPC_CMPB_OFS, {24'h0, b});
    bus(1'b1, TFPC_STATUS_OFS, 32'h1);
    bus(1'b1, TFPC_CTRL_OFS, {24'h0, ctl});
  endtask : cfg

  // Let one full slow period settle, then pads must hold across more than one more
  task automatic hold(input logic ea, input logic eb);
    repeat (520) @(posedge core_clk);
    repeat (8) begin
      repeat (70) @(posedge core_clk);
      chk(pad_a, ea);
      chk(pad_b, eb);
    end
  endtask : hold

  initial begin
    repeat (6) @(posedge core_clk);
    rst_n <= 1'b1;
    foreach (ofs[i]) rdchk(ofs[i], 32'hFFFFFFFF, 32'h0);
    $display("Test reset values done");
    bus(1'b1, TFPC_PIN_OFS, 32'h3);
    cfg(8'hB3, 8'h40, 8'h40);
    repeat (800) @(posedge core_clk);
    chk(per_a, 16'h0100);
    chk(hi_a, 16'h0041);
    chk(per_b, 16'h0100);
    chk(hi_b, 16'h00BF);
    rdchk(TFPC_STATUS_OFS, 32'h1, 32'h1);
    bus(1'b1, TFPC_CMPA_OFS, 32'h80);
    repeat (800) @(posedge core_clk);
    chk(hi_a, 16'h0081);
    timer_tick <= 1'b0;
    bus(1'b0, TFPC_COUNT_OFS, 32'h0);
    c = rd[7:0];
    @(posedge core_clk);
    timer_tick <= 1'b1;
    @(posedge core_clk);
    timer_tick <= 1'b0;
    rdchk(TFPC_COUNT_OFS, 32'hFF, {24'h0, c + 8'h01});
    rdchk(TFPC_COUNT_OFS, 32'hFF, {24'h0, c + 8'h01});
    timer_tick <= 1'b1;
    // A compare write lands in the buffer and must not move this period's edge
    cfg(8'hB3, 8'h40, 8'h40);
    repeat (260) @(posedge core_clk);
    bus(1'b1, TFPC_CMPA_OFS, 32'h10);
    repeat (40) @(posedge core_clk);
    chk(pad_a, 1'b1);
    repeat (600) @(posedge core_clk);
    chk(hi_a, 16'h0011);
    $display("Test fast PWM done");
    cfg(8'hB3, 8'h00, 8'h00);
    repeat (600) @(posedge core_clk);
    chk(hi_a, 16'h0001);
    chk(per_a, 16'h0100);
    cfg(8'hB3, 8'hFF, 8'hFF);
    hold(1'b1, 1'b0);
    bus(1'b1, TFPC_PIN_OFS, 32'h2);
    hold(1'b0, 1'b0);
    $display("Test fast extremes done");
    bus(1'b1, TFPC_PIN_OFS, 32'h3);
    cfg(8'h47, 8'h03, 8'h00);
    repeat (100) @(posedge core_clk);
    chk(per_a, 16'h0008);
    chk(hi_a, 16'h0004);
    cfg(8'h47, 8'h00, 8'h00);
    repeat (100) @(posedge core_clk);
    chk(per_a, 16'h0002);
    bus(1'b1, TFPC_PIN_OFS, 32'h7);
    cfg(8'h43, 8'h10, 8'h10);
    hold(1'b1, 1'b0);
    cfg(8'h41, 8'h10, 8'h10);
    hold(1'b1, 1'b0);
    bus(1'b1, TFPC_PIN_OFS, 32'h3);
    $display("Test toggle done");
    cfg(8'hB1, 8'h40, 8'h40);
    repeat (1600) @(posedge core_clk);
    chk(per_a, 16'h01FE);
    chk(hi_a, 16'h0080);
    chk(per_b, 16'h01FE);
    chk(hi_b, 16'h017E);
    rdchk(TFPC_STATUS_OFS, 32'h1, 32'h1);
    cfg(8'hB1, 8'h00, 8'h00);
    hold(1'b0, 1'b1);
    cfg(8'hB1, 8'hFF, 8'hFF);
    hold(1'b1, 1'b0);
    cfg(8'h25, 8'h10, 8'h08);
    repeat (200) @(posedge core_clk);
    chk(per_b, 16'h0020);
    chk(hi_b, 16'h0010);
    $display("Test phase correct PWM done");
    summarize();
  end
endmodule : tfpc_timer8_tb_top
